// [hw/i2cpr_pkg.sv]
/*
  constants shared by both ends of the paged register port link.
  assumes both ends run on one system clock and meet in i2cpr_if.
*/
// Notes on behaviour
// - address is 010 plus four strap bits
// - eighth bit zero writes, one reads
// - straps decode gnd/scl/sda/vcc as 00..11
// - start is data falling while clock high
// - stop is data rising while clock high
// - device acknowledges matching address byte
// - master stops when address not acknowledged
// - register address byte is acknowledged
// - data bytes msb first, each acknowledged
// - master leaves data high when idle
// - pointer increments at each data acknowledge
// - read is write pointer, restart, read
// - master selects page before paged access
// - page codes duty, scaling, function pages
// - page select resets to duty page
// - page select writes need unlock
// - unlock key grants one page change
// - unlock reads back, resets to zero
// - identification register returns slave address
// - data bytes land in selected page
// - duty and scaling bytes at 01h..c6h
// - function 03h..23h are read only faults
// - writing 2fh in function page resets all registers
package i2cpr_pkg;
  localparam logic [2:0] ADDR_FIXED = 3'h2;
  localparam logic [7:0] REG_OPCFG = 8'h00;
  localparam logic [7:0] REG_GCC = 8'h01;
  localparam logic [7:0] REG_RESSEL = 8'h02;
  localparam logic [7:0] REG_FAULT_LO = 8'h03;
  localparam logic [7:0] REG_FAULT_HI = 8'h23;
  localparam logic [7:0] REG_TEMP = 8'h24;
  localparam logic [7:0] REG_SSPEC = 8'h25;
  localparam logic [7:0] REG_FRESET = 8'h2f;
  localparam logic [7:0] REG_ID = 8'hfc;
  localparam logic [7:0] REG_PAGE = 8'hfd;
  localparam logic [7:0] REG_UNLOCK = 8'hfe;
  localparam logic [7:0] LED_LO = 8'h01;
  localparam logic [7:0] LED_HI = 8'hc6;
  localparam logic [7:0] PAGE_DUTY = 8'h00;
  localparam logic [7:0] PAGE_SCALE = 8'h01;
  localparam logic [7:0] PAGE_FUNC = 8'h02;
  localparam logic [7:0] UNLOCK_KEY = 8'hc5;
  localparam logic [7:0] RESSEL_RST = 8'h33;
  localparam logic [7:0] ZERO8 = 8'h00;
  // strap codes
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SCL = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_VCC = 2'h3;
  // controller avalon register offsets (byte addresses)
  localparam logic [3:0] CSR_CTRL = 4'h0;
  localparam logic [3:0] CSR_ADDR = 4'h4;
  localparam logic [3:0] CSR_DATA = 4'h8;
  localparam logic [3:0] CSR_STAT = 4'hc;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RD = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  // serial clock: 32 ns period at 4 ns system clock
  localparam int SCL_PERIOD_NS = 32;
  localparam int SYS_PERIOD_NS = 4;
  localparam int SCL_HALF_CYC = SCL_PERIOD_NS / SYS_PERIOD_NS / 2;
endpackage : i2cpr_pkg

// [hw/i2cpr_if.sv]
/*
  two-wire link between controller and device end.
  assumes an external pull-up: a line is low only when an end enables its driver.
*/
`timescale 1ns/100ps
interface i2cpr_if;
  logic scl_o_n; // controller clock driver enable, low drives low
  logic sda_m_oe_n; // controller data driver enable, low drives low
  logic sda_s_oe_n; // device data driver enable, low drives low
  logic scl;
  logic sda;
  // wired-and resolution of the open-drain lines
  assign scl = scl_o_n;
  assign sda = sda_m_oe_n & sda_s_oe_n;
  modport ctl (output scl_o_n, output sda_m_oe_n, input scl, input sda);
  modport dev (output sda_s_oe_n, input scl, input sda);
endinterface : i2cpr_if

// [hw/i2cpr_device.sv]
/*
  device end: serial slave with paged register file.
  assumes scl and sda come from outside the clock domain; straps are static.
*/
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module i2cpr_device (
  // system
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // link
  i2cpr_if.dev bus,
  // straps and fault inputs
  input wire logic [1:0] i_address_strap_low,
  input wire logic [1:0] i_address_strap_high,
  input wire logic [7:0] i_fault_bits,
  // register views
  output logic [7:0] o_page_select,
  output logic [7:0] o_operating_configuration
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RECV = 5'b00010,
    S_ACK = 5'b00100,
    S_SEND = 5'b01000,
    S_RACK = 5'b10000
  } i2cpr_dst_t;
  localparam int LEDS = int'(i2cpr_pkg::LED_HI) - int'(i2cpr_pkg::LED_LO) + 1;
  i2cpr_dst_t st_q;
  logic [2:0] scl_s_q, sda_s_q;
  logic [7:0] sh_q, ptr_q, page_q, unlock_q, cfg_q, gcc_q, res_q, temp_q, ss_q;
  logic [7:0] duty_q [LEDS];
  logic [7:0] scale_q [LEDS];
  logic [2:0] bit_q;
  logic [1:0] byte_q; // 0 address, 1 pointer, 2 data
  logic rd_q, ack_ok_q, oe_n_q, full_q;
  logic [3:0] strap_s1_q, strap_s2_q;
  logic scl_r, scl_f, sda_r, sda_f, start_c, stop_c;
  logic [6:0] own_addr;
  logic [7:0] rd_data;
  logic wr_stb;
  logic [7:0] byte_in;

  // two flops before use, third stage for edges
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
    end
  end
  assign scl_r = scl_s_q[1] & ~scl_s_q[2];
  assign scl_f = ~scl_s_q[1] & scl_s_q[2];
  assign sda_r = sda_s_q[1] & ~sda_s_q[2];
  assign sda_f = ~sda_s_q[1] & sda_s_q[2];
  assign start_c = sda_f & scl_s_q[1] & scl_s_q[2];
  assign stop_c = sda_r & scl_s_q[1] & scl_s_q[2];

  // straps are pins: two flops before the address compare reads them
  always_ff @(posedge i_clk_sys) begin
    strap_s1_q <= {i_address_strap_high, i_address_strap_low};
    strap_s2_q <= strap_s1_q;
  end
  // strap decode: gnd 00, scl 01, sda 10, vcc 11
  assign own_addr = {i2cpr_pkg::ADDR_FIXED, strap_s2_q};
  assign byte_in = {sh_q[6:0], sda_s_q[1]};

  function automatic logic in_led(input logic [7:0] a);
    in_led = (a >= i2cpr_pkg::LED_LO) && (a <= i2cpr_pkg::LED_HI);
  endfunction : in_led

  function automatic logic [7:0] led_idx(input logic [7:0] a);
    led_idx = a - i2cpr_pkg::LED_LO;
  endfunction : led_idx

  // read data mux
  always_comb begin
    rd_data = i2cpr_pkg::ZERO8;
    if (ptr_q == i2cpr_pkg::REG_ID) rd_data = {own_addr, 1'b0};
    else if (ptr_q == i2cpr_pkg::REG_UNLOCK) rd_data = unlock_q;
    else if (page_q == i2cpr_pkg::PAGE_DUTY && in_led(ptr_q)) rd_data = duty_q[led_idx(ptr_q)];
    else if (page_q == i2cpr_pkg::PAGE_SCALE && in_led(ptr_q)) rd_data = scale_q[led_idx(ptr_q)];
    else if (page_q == i2cpr_pkg::PAGE_FUNC) begin
      if (ptr_q == i2cpr_pkg::REG_OPCFG) rd_data = cfg_q;
      else if (ptr_q == i2cpr_pkg::REG_GCC) rd_data = gcc_q;
      else if (ptr_q == i2cpr_pkg::REG_RESSEL) rd_data = res_q;
      else if (ptr_q >= i2cpr_pkg::REG_FAULT_LO && ptr_q <= i2cpr_pkg::REG_FAULT_HI)
        rd_data = i_fault_bits;
      else if (ptr_q == i2cpr_pkg::REG_TEMP) rd_data = temp_q;
      else if (ptr_q == i2cpr_pkg::REG_SSPEC) rd_data = ss_q;
    end
  end

  // protocol state machine
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q <= S_IDLE;
      sh_q <= i2cpr_pkg::ZERO8;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      rd_q <= 1'b0;
      ack_ok_q <= 1'b0;
      oe_n_q <= 1'b1;
      full_q <= 1'b0;
    end else if (start_c) begin
      st_q <= S_RECV;
      full_q <= 1'b0;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      oe_n_q <= 1'b1;
    end else if (stop_c) begin
      st_q <= S_IDLE;
      oe_n_q <= 1'b1;
    end else begin
      unique case (st_q)
        S_IDLE: oe_n_q <= 1'b1;
        S_RECV: begin
          if (scl_r) begin
            sh_q <= byte_in;
            bit_q <= bit_q + 3'h1;
            full_q <= (bit_q == 3'h7); // eighth bit sampled
          end
          // the first fall after a start carries no byte, so wait for eight rises
          if (scl_f && full_q) begin
            // full byte in: decide acknowledge
            full_q <= 1'b0;
            if (byte_q == 2'h0) begin
              ack_ok_q <= (sh_q[7:1] == own_addr);
              rd_q <= sh_q[0];
            end else begin
              ack_ok_q <= 1'b1;
            end
            oe_n_q <= !((byte_q != 2'h0) || (sh_q[7:1] == own_addr));
            st_q <= S_ACK;
          end
        end
        S_ACK: if (scl_f) begin
          if (!ack_ok_q) begin
            st_q <= S_IDLE;
            oe_n_q <= 1'b1;
          end else if (byte_q == 2'h0 && rd_q) begin
            st_q <= S_SEND;
            sh_q <= rd_data;
            oe_n_q <= rd_data[7];
            bit_q <= 3'h1;
          end else begin
            st_q <= S_RECV;
            oe_n_q <= 1'b1;
            bit_q <= 3'h0;
            if (byte_q != 2'h2) byte_q <= byte_q + 2'h1;
          end
        end
        S_SEND: if (scl_f) begin
          if (bit_q == 3'h0) begin
            oe_n_q <= 1'b1;
            st_q <= S_RACK;
          end else begin
            oe_n_q <= sh_q[3'h7 - bit_q];
            bit_q <= bit_q + 3'h1;
          end
        end
        S_RACK: begin
          if (scl_r) ack_ok_q <= ~sda_s_q[1];
          if (scl_f) begin
            if (ack_ok_q) begin
              st_q <= S_SEND;
              sh_q <= rd_data;
              oe_n_q <= rd_data[7];
              bit_q <= 3'h1;
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // data byte write strobe at the start of its acknowledge
  assign wr_stb = (st_q == S_RECV) && scl_f && full_q && byte_q == 2'h2 && !start_c
    && !stop_c;

  // pointer load and auto increment
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ptr_q <= i2cpr_pkg::ZERO8;
    end else if ((st_q == S_RECV) && scl_f && full_q && byte_q == 2'h1 && !start_c) begin
      ptr_q <= sh_q;
    end else if (wr_stb) begin
      ptr_q <= ptr_q + 8'h01;
    end else if (st_q == S_RACK && scl_f && ack_ok_q) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // page select and one-shot unlock
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || (wr_stb && page_q == i2cpr_pkg::PAGE_FUNC && ptr_q == i2cpr_pkg::REG_FRESET)) begin
      page_q <= i2cpr_pkg::PAGE_DUTY;
      unlock_q <= i2cpr_pkg::ZERO8;
    end else if (wr_stb && ptr_q == i2cpr_pkg::REG_PAGE) begin
      if (unlock_q == i2cpr_pkg::UNLOCK_KEY) begin
        page_q <= sh_q;
        unlock_q <= i2cpr_pkg::ZERO8;
      end
    end else if (wr_stb && ptr_q == i2cpr_pkg::REG_UNLOCK) begin
      unlock_q <= sh_q;
    end
  end

  // function page registers
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || (wr_stb && page_q == i2cpr_pkg::PAGE_FUNC && ptr_q == i2cpr_pkg::REG_FRESET)) begin
      cfg_q <= i2cpr_pkg::ZERO8;
      gcc_q <= i2cpr_pkg::ZERO8;
      res_q <= i2cpr_pkg::RESSEL_RST;
      temp_q <= i2cpr_pkg::ZERO8;
      ss_q <= i2cpr_pkg::ZERO8;
    end else if (wr_stb && page_q == i2cpr_pkg::PAGE_FUNC) begin
      unique case (ptr_q)
        i2cpr_pkg::REG_OPCFG: cfg_q <= sh_q;
        i2cpr_pkg::REG_GCC: gcc_q <= sh_q;
        i2cpr_pkg::REG_RESSEL: res_q <= sh_q;
        i2cpr_pkg::REG_TEMP: temp_q <= sh_q;
        i2cpr_pkg::REG_SSPEC: ss_q <= sh_q;
        default: cfg_q <= cfg_q; // fault bytes are read only
      endcase
    end
  end

  // per-led duty and scaling arrays
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || (wr_stb && page_q == i2cpr_pkg::PAGE_FUNC && ptr_q == i2cpr_pkg::REG_FRESET)) begin
      for (int i = 0; i < LEDS; i++) begin
        duty_q[i] <= i2cpr_pkg::ZERO8;
        scale_q[i] <= i2cpr_pkg::ZERO8;
      end
    end else if (wr_stb && in_led(ptr_q)) begin
      if (page_q == i2cpr_pkg::PAGE_DUTY) duty_q[led_idx(ptr_q)] <= sh_q;
      else if (page_q == i2cpr_pkg::PAGE_SCALE) scale_q[led_idx(ptr_q)] <= sh_q;
    end
  end

  assign bus.sda_s_oe_n = oe_n_q;
  assign o_page_select = page_q;
  assign o_operating_configuration = cfg_q;
endmodule : i2cpr_device

// [hw/i2cpr_ctl.sv]
/*
  controller end: avalon-mm slave that runs single-byte serial transfers.
  assumes the device end sits on the same i2cpr_if.
*/
`timescale 1ns/100ps
module i2cpr_ctl (
  // system
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // avalon-mm
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // link
  i2cpr_if.ctl bus
);
  typedef enum logic [5:0] {
    C_IDLE = 6'b000001, C_START = 6'b000010, C_BIT = 6'b000100,
    C_ACK = 6'b001000, C_STOP = 6'b010000, C_DONE = 6'b100000
  } i2cpr_cst_t;
  localparam logic [7:0] HALF = 8'(i2cpr_pkg::SCL_HALF_CYC);
  i2cpr_cst_t st_q;
  logic [7:0] cnt_q, sh_q, dev_q, reg_q, data_q, rdat_q;
  logic [2:0] bit_q;
  logic [2:0] phase_q; // 0 devw,1 reg,2 data,3 restart/devr,4 read
  logic rd_q, busy_q, nack_q, scl_q, sda_q, wait_q;
  logic [1:0] sda_s_q;
  logic tick;
  logic [31:0] rdata_d;

  assign tick = (cnt_q == HALF - 8'h01);
  // sample the shared data line through two flops
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) sda_s_q <= 2'h3;
    else sda_s_q <= {sda_s_q[0], bus.sda};
  end
  // half period counter
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || st_q == C_IDLE || tick) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end

  // avalon slave: one wait cycle then answer
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (i_avs_address)
      i2cpr_pkg::CSR_ADDR: rdata_d = {16'h0000, dev_q, reg_q};
      i2cpr_pkg::CSR_DATA: rdata_d = {16'h0000, rdat_q, data_q};
      i2cpr_pkg::CSR_STAT: rdata_d = {30'h0000_0000, nack_q, busy_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wait_q <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      wait_q <= !(wait_q && (i_avs_read || i_avs_write));
      if (i_avs_read && wait_q) o_avs_readdata <= rdata_d;
    end
  end
  assign o_avs_waitrequest = wait_q;

  // transfer engine; a go write while busy is ignored
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q <= C_IDLE; dev_q <= 8'h00; reg_q <= 8'h00; data_q <= 8'h00; rdat_q <= 8'h00;
      sh_q <= 8'h00; bit_q <= 3'h0; phase_q <= 3'h0; rd_q <= 1'b0; busy_q <= 1'b0;
      nack_q <= 1'b0; scl_q <= 1'b1; sda_q <= 1'b1;
    end else begin
      // a write takes effect at the edge after its wait ends, while waitrequest is low
      if (i_avs_write && !wait_q && !busy_q) begin
        if (i_avs_address == i2cpr_pkg::CSR_ADDR) begin
          dev_q <= i_avs_writedata[15:8]; reg_q <= i_avs_writedata[7:0];
        end
        if (i_avs_address == i2cpr_pkg::CSR_DATA) data_q <= i_avs_writedata[7:0];
        if (i_avs_address == i2cpr_pkg::CSR_CTRL && i_avs_writedata[i2cpr_pkg::CTRL_GO]) begin
          rd_q <= i_avs_writedata[i2cpr_pkg::CTRL_RD];
          busy_q <= 1'b1; nack_q <= 1'b0; phase_q <= 3'h0; st_q <= C_START;
        end
      end
      if (tick) begin
        unique case (st_q)
          C_IDLE: scl_q <= 1'b1;
          C_START: begin
            if (scl_q && sda_q) sda_q <= 1'b0;
            else if (scl_q) begin
              scl_q <= 1'b0; bit_q <= 3'h0; st_q <= C_BIT;
              sh_q <= (phase_q == 3'h3) ? {dev_q[6:0], 1'b1} : {dev_q[6:0], 1'b0};
            end else begin
              scl_q <= 1'b1; sda_q <= 1'b1;
            end
          end
          C_BIT: begin // msb first
            if (!scl_q) begin
              sda_q <= (phase_q == 3'h4) ? 1'b1 : sh_q[3'h7 - bit_q]; scl_q <= 1'b1;
            end else begin
              if (phase_q == 3'h4) rdat_q <= {rdat_q[6:0], sda_s_q[1]};
              scl_q <= 1'b0; bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) st_q <= C_ACK;
            end
          end
          C_ACK: begin
            if (!scl_q) begin
              sda_q <= 1'b1; // released for the acknowledge; a single read byte gets none
              scl_q <= 1'b1;
            end else begin
              scl_q <= 1'b0;
              if (phase_q != 3'h4 && sda_s_q[1]) begin
                nack_q <= 1'b1; st_q <= C_STOP;
              end else if (phase_q == 3'h0) begin
                phase_q <= 3'h1; sh_q <= reg_q; st_q <= C_BIT;
              end else if (phase_q == 3'h1 && !rd_q) begin
                phase_q <= 3'h2; sh_q <= data_q; st_q <= C_BIT;
              end else if (phase_q == 3'h1) begin
                phase_q <= 3'h3; st_q <= C_START; // restart
              end else if (phase_q == 3'h3) begin
                phase_q <= 3'h4; st_q <= C_BIT;
              end else st_q <= C_STOP;
              bit_q <= 3'h0;
            end
          end
          C_STOP: begin
            if (!scl_q) begin sda_q <= 1'b0; scl_q <= 1'b1; end
            else begin sda_q <= 1'b1; st_q <= C_DONE; end
          end
          C_DONE: begin busy_q <= 1'b0; st_q <= C_IDLE; end
          default: st_q <= C_IDLE;
        endcase
      end
    end
  end
  assign bus.scl_o_n = scl_q;
  assign bus.sda_m_oe_n = sda_q;
endmodule : i2cpr_ctl

// [verification/i2cpr_props.sv]
/*
  checker for the two-wire link that joins the controller and device ends.
  assumes every link signal is registered in the system clock domain.
*/
`timescale 1ns/100ps
module i2cpr_props (
  // system
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // link
  input wire logic scl_o_n,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda,
  // address the device should answer to
  input wire logic [6:0] i_dev_addr
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic scl_q;
  logic sda_q;
  logic first_q;
  logic rd_q;
  logic [3:0] nbit_q;
  logic [7:0] sh_q;
  logic [7:0] low_q;
  logic start_w;
  logic rise_w;
  // link events seen on the system clock
  assign start_w = scl & scl_q & sda_q & ~sda;
  assign rise_w = scl & ~scl_q;
  // previous line levels
  always_ff @(posedge i_clk_sys) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // bit counter and byte shifter, restarted at every start
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || start_w) begin
      nbit_q <= 4'h0;
      first_q <= 1'b1;
    end else if (rise_w && nbit_q == 4'h8) begin
      nbit_q <= 4'h0;
      first_q <= 1'b0;
      if (first_q) rd_q <= sh_q[0];
    end else if (rise_w) begin
      nbit_q <= nbit_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
    end
  end
  // length of one unbroken device drive
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || sda_s_oe_n) low_q <= 8'h00;
    else if (low_q != 8'hff) low_q <= low_q + 8'h01;
  end
  sequence s_ack_slot;
    rise_w && nbit_q == 4'h8;
  endsequence
  sequence s_stop;
    scl && scl_q && !sda_q && sda;
  endsequence
  property p_addr_ack;
    s_ack_slot ##0 first_q |-> sda_s_oe_n == (sh_q[7:1] != i_dev_addr);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_data_ack;
    s_ack_slot ##0 (!first_q && !rd_q) |-> !sda_s_oe_n;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("written byte not acked");
  property p_master_release;
    s_ack_slot |-> sda_m_oe_n;
  endproperty
  a_master_release: assert property (p_master_release) else $error("master holds ack");
  property p_dev_stable;
    scl && $past(scl) |-> $stable(sda_s_oe_n);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("device data moved");
  property p_start_master;
    start_w |-> !sda_m_oe_n && sda_s_oe_n;
  endproperty
  a_start_master: assert property (p_start_master) else $error("start not by master");
  property p_stop_idle;
    s_stop |=> (scl && sda) [*2];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
  property p_scl_high;
    rise_w |-> scl [*4];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_dev_release;
    low_q < 8'd80;
  endproperty
  a_dev_release: assert property (p_dev_release) else $error("device holds data");
  property p_dev_drive_low;
    $fell(sda_s_oe_n) |-> !scl;
  endproperty
  a_dev_drive_low: assert property (p_dev_drive_low) else $error("device drove in high");
endmodule : i2cpr_props

// [verification/tb.sv]
/*
  self-checking bench: controller and device ends joined on one link.
  assumes the controller's avalon side is the only way into the link.
*/
`timescale 1ns/100ps
module tb;
  logic i_clk_sys;
  logic i_sys_rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] strap_low;
  logic [1:0] strap_high;
  logic [7:0] fault_bits;
  logic [7:0] page_select;
  logic [7:0] op_cfg;
  logic [6:0] dev_addr;
  int mismatches;
  int n_compared;
  int cycles;
  integer seed;
  int mem [0:2][0:255];
  int page_m;
  int unl_m;
  int regs [5] = '{0, 1, 'h5a, 'hc6, 'hc7};
  int fregs [9] = '{0, 1, 2, 3, 'h10, 'h23, 'h24, 'h25, 'h26};
  // expected slave address
  assign dev_addr = {i2cpr_pkg::ADDR_FIXED, strap_high, strap_low};
  i2cpr_if link ();
  i2cpr_ctl i_i2cpr_ctl (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .bus(link));
  i2cpr_device i_i2cpr_device (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .bus(link),
    .i_address_strap_low(strap_low), .i_address_strap_high(strap_high),
    .i_fault_bits(fault_bits), .o_page_select(page_select),
    .o_operating_configuration(op_cfg));
  i2cpr_props i_i2cpr_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .scl_o_n(link.scl_o_n), .sda_m_oe_n(link.sda_m_oe_n), .sda_s_oe_n(link.sda_s_oe_n),
    .scl(link.scl), .sda(link.sda), .i_dev_addr(dev_addr));
  // system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // hang guard
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one avalon cycle, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge i_clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge i_clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge i_clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  // one single-byte serial transfer through the controller
  task automatic xfer(input logic rd, input logic [6:0] a7, input logic [7:0] r,
                      input logic [7:0] d, output logic [7:0] q, output logic nk);
    logic [31:0] s;
    av(1'b1, i2cpr_pkg::CSR_ADDR, {17'h0_0000, a7, r}, s);
    av(1'b1, i2cpr_pkg::CSR_DATA, {24'h00_0000, d}, s);
    av(1'b1, i2cpr_pkg::CSR_CTRL, {30'h0000_0000, rd, 1'b1}, s);
    s = 32'h0000_0001;
    while (s[i2cpr_pkg::STAT_BUSY] !== 1'b0) av(1'b0, i2cpr_pkg::CSR_STAT, 32'h0000_0000, s);
    nk = s[i2cpr_pkg::STAT_NACK];
    av(1'b0, i2cpr_pkg::CSR_DATA, 32'h0000_0000, s);
    q = s[15:8];
  endtask : xfer
  // register file model
  task automatic m_clear();
    foreach (mem[p, r]) mem[p][r] = 0;
    mem[2][2] = i2cpr_pkg::RESSEL_RST;
    page_m = 0;
    unl_m = 0;
  endtask : m_clear
  function automatic logic [7:0] m_rd(input int r);
    if (r == i2cpr_pkg::REG_ID) return {dev_addr, 1'b0};
    if (r == i2cpr_pkg::REG_UNLOCK) return 8'(unl_m);
    if (page_m > 2) return 8'h00;
    if (page_m == 2 && r >= 3 && r <= 'h23) return fault_bits;
    return 8'(mem[page_m][r]);
  endfunction : m_rd
  task automatic m_wr(input int r, input int v);
    if (r == i2cpr_pkg::REG_UNLOCK) unl_m = v;
    else if (r == i2cpr_pkg::REG_PAGE) begin
      if (unl_m == i2cpr_pkg::UNLOCK_KEY) begin
        page_m = v;
        unl_m = 0;
      end
    end else if (page_m == 2 && r == 'h2f) m_clear();
    else if (page_m < 2 && r >= 1 && r <= 'hc6) mem[page_m][r] = v;
    else if (page_m == 2 && (r <= 2 || r == 'h24 || r == 'h25)) mem[2][r] = v;
  endtask : m_wr
  // one register access, checked against the model
  task automatic op(input logic rd, input logic [7:0] r, input logic [7:0] d);
    logic [7:0] q;
    logic nk;
    xfer(rd, dev_addr, r, d, q, nk);
    chk({7'h00, nk}, 8'h00);
    if (rd) chk(q, m_rd(r));
    else m_wr(r, d);
    chk(page_select, 8'(page_m));
  endtask : op
  task automatic sel(input logic [7:0] p);
    op(1'b0, i2cpr_pkg::REG_UNLOCK, i2cpr_pkg::UNLOCK_KEY);
    op(1'b0, i2cpr_pkg::REG_PAGE, p);
  endtask : sel
  task automatic rst();
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    m_clear();
  endtask : rst
  // main sequence
  initial begin
    logic [7:0] q;
    logic nk;
    seed = 32'h573d;
    i_sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {strap_low, strap_high} = 4'h6;
    fault_bits = 8'($random(seed));
    m_clear();
    repeat (3) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    chk(page_select, 8'h00);
    op(1'b1, i2cpr_pkg::REG_UNLOCK, 8'h00);
    op(1'b0, i2cpr_pkg::REG_PAGE, 8'h01);
    sel(8'h01);
    op(1'b1, i2cpr_pkg::REG_UNLOCK, 8'h00);
    op(1'b0, i2cpr_pkg::REG_PAGE, 8'h02);
    op(1'b0, i2cpr_pkg::REG_UNLOCK, 8'h3c);
    op(1'b1, i2cpr_pkg::REG_UNLOCK, 8'h00);
    for (int p = 0; p < 4; p++) begin
      sel(8'(p % 2));
      foreach (regs[i]) op(p > 1, 8'(regs[i]), 8'($random(seed)));
    end
    sel(8'h02);
    foreach (fregs[i]) op(1'b1, 8'(fregs[i]), 8'h00);
    foreach (fregs[i]) op(1'b0, 8'(fregs[i]), 8'($random(seed)));
    foreach (fregs[i]) op(1'b1, 8'(fregs[i]), 8'h00);
    chk(op_cfg, 8'(mem[2][0]));
    op(1'b0, i2cpr_pkg::REG_FRESET, 8'($random(seed)));
    chk(op_cfg, 8'h00);
    sel(8'h02);
    op(1'b1, i2cpr_pkg::REG_RESSEL, 8'h00);
    op(1'b1, i2cpr_pkg::REG_FRESET, 8'h00);
    sel(8'h03);
    op(1'b0, 8'h01, 8'h77);
    op(1'b1, 8'h01, 8'h00);
    xfer(1'b0, dev_addr ^ 7'h04, 8'h01, 8'h55, q, nk);
    chk({7'h00, nk}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      strap_low <= 2'(i);
      strap_high <= 2'(3 - i);
      rst();
      op(1'b1, i2cpr_pkg::REG_ID, 8'h00);
    end
    stop_test();
  end
endmodule : tb
